//--- bench/sltp_pattern_gen_properties.sv
// port-level assertions for the serial link test pattern generator
`timescale 1ns/1ps
module sltp_pattern_gen_props #(
    parameter NUM_CONV   = 2,
    parameter SAMP_FRAME = 2
) (
    // clock and reset
    input wire        clk_sys,
    input wire        rst_n,
    // register port
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [11:0] reg_addr,
    input wire [7:0]  reg_wdata,
    input wire [7:0]  reg_rdata,
    // sample and sync inputs
    input wire [15:0] sample_in,
    input wire        link_sync_request_in_n,
    // pattern stream and status
    input wire        pat_valid,
    input wire        pat_ready,
    input wire [15:0] pat_data,
    input wire [1:0]  pat_inject_point,
    input wire        pat_active,
    input wire [2:0]  link_test_sel,
    input wire        link_sync_req_n,
    input wire        soft_reset_pulse
);
    logic       sync_ign_reg;
    logic [2:0] lsel_reg;
    wire        mode_wr = reg_wr && reg_addr == 12'h573;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // shadows of sync control and link test writes; soft reset clears both
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            sync_ign_reg <= 1'b0;
            lsel_reg     <= 3'h0;
        end else if (reg_wr && reg_addr == 12'h000 && reg_wdata == 8'h81) begin
            sync_ign_reg <= 1'b0;
            lsel_reg     <= 3'h0;
        end else begin
            if (reg_wr && reg_addr == 12'h572) sync_ign_reg <= reg_wdata == 8'hC0;
            if (reg_wr && reg_addr == 12'h574) lsel_reg <= reg_wdata[2:0];
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    property p_pulse_cause;
        reg_wr && reg_addr == 12'h000 && reg_wdata == 8'h81 |-> ##[1:2] soft_reset_pulse;
    endproperty
    a_pulse_cause: assert property (p_pulse_cause) else $error("no soft reset pulse");
    property p_pulse_single;
        soft_reset_pulse |=> !soft_reset_pulse;
    endproperty
    a_pulse_single: assert property (p_pulse_single) else $error("long reset pulse");
    property p_stall_hold;
        pat_valid && !pat_ready && !soft_reset_pulse |=> pat_valid && $stable(pat_data);
    endproperty
    a_stall_hold: assert property (p_stall_hold) else $error("word lost in stall");
    property p_sync_ign;
        sync_ign_reg && $past(sync_ign_reg) |-> link_sync_req_n;
    endproperty
    a_sync_ign: assert property (p_sync_ign) else $error("sync request not ignored");
    property p_active_on;
        mode_wr && reg_wdata[3:0] != 4'h0 |-> ##[1:2] pat_active;
    endproperty
    a_active_on: assert property (p_active_on) else $error("pattern not active");
    property p_inj_field;
        mode_wr && reg_wdata[3:0] != 4'h0 |=> pat_inject_point == $past(reg_wdata[5:4]);
    endproperty
    a_inj_field: assert property (p_inj_field) else $error("wrong injection point");
    property p_link_sel;
        reg_wr && reg_addr == 12'h574 |-> ##[1:2] link_test_sel == lsel_reg;
    endproperty
    a_link_sel: assert property (p_link_sel) else $error("wrong link test select");
    property p_refuse_off;
        mode_wr && reg_wdata[3:0] == 4'h0 && pat_active |=> pat_active [*2];
    endproperty
    a_refuse_off: assert property (p_refuse_off) else $error("mode off not refused");
endmodule // sltp_pattern_gen_props

//--- bench/sltp_rx_model.sv
// receiver model: takes pattern words, stalls on command, drives the sync request
`timescale 1ns/1ps
module sltp_rx_model (
    // clock and reset
    input  wire        clk_sys,
    input  wire        rst_n,
    // pattern stream
    input  wire        pat_valid,
    input  wire [15:0] pat_data,
    output logic       pat_ready,
    // bench control: stall 0 never, 1 every other cycle, 2 held off
    input  wire [1:0]  stall,
    input  wire        sync_req,
    // sync request to the block, active low
    output logic       link_sync_request_in_n
);
    logic [15:0] got[$];

    // log words in arrival order; ready toggles so the skid buffer is exercised
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            pat_ready              <= 1'b0;
            link_sync_request_in_n <= 1'b1;
        end else begin
            if (pat_valid && pat_ready) got.push_back(pat_data);
            pat_ready              <= stall == 2'd0 || (stall == 2'd1 && !pat_ready);
            link_sync_request_in_n <= !sync_req;
        end
    end
endmodule // sltp_rx_model

//--- bench/tb_sltp_pattern_gen.sv
// self-checking bench for the serial link test pattern generator
`timescale 1ns/1ps
module tb_sltp_pattern_gen;
    logic        clk_sys, rst_n, reg_wr, reg_rd, sync_req, link_sync_request_in_n;
    logic        pat_valid, pat_ready, pat_active, link_sync_req_n, soft_reset_pulse;
    logic [1:0]  stall, pat_inject_point;
    logic [2:0]  link_test_sel;
    logic [7:0]  reg_wdata, reg_rdata;
    logic [11:0] reg_addr;
    logic [15:0] sample_in, pat_data, msk, v;
    logic [15:0] exp_w[0:11];
    logic [15:0] up[0:3] = '{16'hA5C3, 16'h3C96, 16'hF00F, 16'h1248};
    logic [7:0]  plan[0:15] = '{8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18,
                                8'h1E, 8'h1F, 8'h01, 8'h0E, 8'h04, 8'h2E, 8'h21, 8'h28};
    logic [31:0] s;
    int          failures, n_compared, i, j, k, o, rep, wd, tp;

    sltp_pattern_gen DUT (.*);
    sltp_rx_model RX (.*);

    // 40 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [15:0] got, input logic [15:0] want);
        n_compared++;
        if (got !== want) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask

    // register write: strobe held for exactly the one sampling edge
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask

    // register read: data is registered, so look just after the sampling edge
    task automatic rd(input logic [11:0] a, input logic [7:0] want);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1 check({8'h00, reg_rdata}, {8'h00, want});
    endtask

    task automatic report_and_stop;
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // clear the receive log and wait, bounded, for n words
    task automatic grab(input int n);
        RX.got.delete();
        for (k = 0; k < 400 && RX.got.size() < n; k++) @(posedge clk_sys);
        if (RX.got.size() < n) begin
            failures++;
            report_and_stop();
        end
    endtask

    // expected words for one {injection, mode} entry, repeated and masked
    task automatic build(input logic [7:0] ent);
        rep = ent[5:4] == 2'b00 ? 4 : 1;
        msk = ent[5] ? 16'h00FF : ent[4] ? 16'h03FF : 16'hFFFF;
        case (ent[3:0])
            4'h3: {wd, tp, s} = {32'd31, 32'd28, 32'h0003AFFF};
            4'h4: {wd, tp, s} = {32'd23, 32'd18, 32'h00003AFF};
            4'h5: {wd, tp, s} = {32'd15, 32'd14, 32'h000003AF};
            4'h6: {wd, tp, s} = {32'd9, 32'd5, 32'h00000092};
            4'h7: {wd, tp, s} = {32'd7, 32'd6, 32'h00000007};
            default: {wd, tp, s} = {32'd9, 32'd5, 32'h00000000};
        endcase
        for (j = 0; j < 12; j++) begin
            case (ent[3:0])
                4'h1: v = j[0] ? 16'hAAAA : 16'h5555;
                4'h2: v = j[0] ? 16'hFFFF : 16'h0000;
                4'h8: v = 16'(j);
                4'hE: v = up[j % 4] >> (ent[5] ? 9 : ent[4] ? 6 : 0);
                4'hF: v = j < 4 ? up[j % 4] >> (ent[5] ? 9 : ent[4] ? 6 : 0) : 16'h0000;
                default: v = s[15:0];
            endcase
            s = ((s << 1) | 32'(s[wd - 1] ^ s[tp - 1])) & ((32'h1 << wd) - 1);
            for (k = j * rep; k < j * rep + rep && k < 12; k++) exp_w[k] = v & msk;
        end
    endtask

    // skip stale words of the previous mode, then compare twelve in a row
    task automatic cmp_seq;
        o = 0;
        for (k = 5; k >= 0; k--)
            if ((RX.got[k] & msk) === exp_w[0] && (RX.got[k + 1] & msk) === exp_w[1]) o = k;
        for (k = 0; k < 12; k++) begin
            check(RX.got[o + k] & msk, exp_w[k]);
        end
    endtask

    initial begin
        rst_n     = 1'b0;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 12'h000;
        reg_wdata = 8'h00;
        sample_in = 16'h1234;
        stall     = 2'd0;
        sync_req  = 1'b0;
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        // reset values, unmapped and user space, transport sample test
        rd(12'h573, 8'h00);
        rd(12'h574, 8'h00);
        rd(12'h575, 8'h00);
        rd(12'h551, 8'h00);
        wr(12'h571, 8'h20);
        rd(12'h571, 8'h20);
        rd(12'h574, 8'h80);
        grab(6);
        for (i = 2; i < 6; i++) check(RX.got[i], 16'h1234);
        wr(12'h571, 8'h00);
        $display("test registers and transport done");
        // user words, then every mode at the 10-bit point, modes 1, 4, E at sample and 1, 8, E at 8-bit, receiver stalling
        for (i = 0; i < 8; i++) wr(12'h551 + 12'(i), i[0] ? up[i / 2][15:8] : up[i / 2][7:0]);
        stall <= 2'd1;
        for (i = 0; i < 16; i++) begin
            build(plan[i]);
            wr(12'h573, plan[i]);
            if (i == 7) begin
                stall <= 2'd2;
                repeat (10) @(posedge clk_sys);
                #1 check({15'h0000, pat_valid}, 16'h0001);
                @(posedge clk_sys);
                stall <= 2'd1;
            end
            grab(18);
            cmp_seq();
            $display("test pattern %h done", plan[i]);
        end
        // mode off is refused until the soft reset
        wr(12'h573, 8'h00);
        rd(12'h573, 8'h28);
        wr(12'h000, 8'h81);
        repeat (3) @(posedge clk_sys);
        rd(12'h573, 8'h00);
        $display("test soft reset done");
        // every link layer test code, then sync request ignore and pass
        for (i = 0; i < 8; i++) begin
            wr(12'h574, 8'(i));
            @(posedge clk_sys);
            #1 check({13'h0000, link_test_sel}, 16'(i));
        end
        sync_req <= 1'b1;
        wr(12'h572, 8'hC0);
        repeat (4) @(posedge clk_sys);
        #1 check({15'h0000, link_sync_req_n}, 16'h0001);
        wr(12'h572, 8'h00);
        repeat (4) @(posedge clk_sys);
        #1 check({15'h0000, link_sync_req_n}, 16'h0000);
        $display("test link layer and sync done");
        report_and_stop();
    end
endmodule // tb_sltp_pattern_gen

bind sltp_pattern_gen sltp_pattern_gen_props #(.NUM_CONV(NUM_CONV), .SAMP_FRAME(SAMP_FRAME))
    u_props (.*);

//--- rtl/sltp_consts.vh
// register offsets, field positions, reset values and pattern constants for the test pattern block
`ifndef SLTP_CONSTS_VH
`define SLTP_CONSTS_VH

// register offsets
`define SLTP_OFS_TRANSPORT_TEST   12'h571
`define SLTP_OFS_SYNC_CTRL        12'h572
`define SLTP_OFS_IFACE_TEST       12'h573
`define SLTP_OFS_LINK_TEST        12'h574
`define SLTP_OFS_USER_BASE        12'h551
`define SLTP_OFS_SOFT_RESET       12'h000

// field positions and values
`define SLTP_TRANSPORT_EN_BIT     5
`define SLTP_SOFT_RESET_VAL       8'h81
`define SLTP_SYNC_IGNORE_VAL      8'hC0
`define SLTP_REG_RESET            8'h00

// interface test modes
`define SLTP_MODE_OFF             4'h0
`define SLTP_MODE_CHECKER         4'h1
`define SLTP_MODE_TOGGLE          4'h2
`define SLTP_MODE_PN31            4'h3
`define SLTP_MODE_PRBS_TWENTYTHREE_PATTERN            4'h4
`define SLTP_MODE_PN15            4'h5
`define SLTP_MODE_PN9             4'h6
`define SLTP_MODE_PN7             4'h7
`define SLTP_MODE_RAMP            4'h8
`define SLTP_MODE_USER_REPEAT     4'hE
`define SLTP_MODE_USER_SINGLE     4'hF

// injection points
`define SLTP_INJ_SAMPLE           2'b00
`define SLTP_INJ_PHY10            2'b01
`define SLTP_INJ_SCR8             2'b10

// checkerboard words and seeds
`define SLTP_CHECKER_A            16'h5555
`define SLTP_CHECKER_B            16'hAAAA
`define SLTP_SEED_PN31            31'h0003AFFF
`define SLTP_SEED_PRBS_TWENTYTHREE_PATTERN            23'h003AFF
`define SLTP_SEED_PN15            15'h03AF
`define SLTP_SEED_PN9             9'h092
`define SLTP_SEED_PN7             7'h07

`endif

//--- rtl/sltp_pattern_gen.v
// serial link test pattern generator with byte-wide register port
`timescale 1ns/1ps
`include "sltp_consts.vh"

// Contract
// - transport sample test bit replaces normal data with raw sample stream; here the bit only sets pat_active, mode 0 sends sample_in either way
// - low four bits of test control pick the pattern; zero means off
// - injection field: 00 sample input, 01 10-bit symbols, 10 8-bit octets
// - mode 1 alternates 5555/AAAA; mode 2 toggles zeros and ones
// - PN modes use listed polynomials and seeds for 31,23,15,9,7 bits
// - ramp counts up by one, wrapping at injection word width
// - mode E loops through four user words continuously
// - mode F sends four user words once then zeros
// - sample injection: all samples in a frame share one word, advance per frame
// - 10-bit injection uses user bits 15:6 and 155/2AA checkerboard
// - 8-bit injection uses user bits 15:9 and 55/AA checkerboard
// - three-bit link layer test field selects link layer test sequences
// - leaving test mode needs soft reset write of 81, bit clears itself
module sltp_pattern_gen #(
    parameter NUM_CONV    = 2,
    parameter SAMP_FRAME  = 2
) (
    // clock and reset
    input  wire        clk_sys,
    input  wire        rst_n,
    // register port
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [11:0] reg_addr,
    input  wire [7:0]  reg_wdata,
    output reg  [7:0]  reg_rdata,
    // normal data and link sync
    input  wire [15:0] sample_in,
    input  wire        link_sync_request_in_n,
    // pattern output stream
    output wire        pat_valid,
    input  wire        pat_ready,
    output wire [15:0] pat_data,
    output wire [1:0]  pat_inject_point,
    output reg         pat_active,
    output reg  [2:0]  link_test_sel,
    output wire        link_sync_req_n,
    output reg         soft_reset_pulse
);

    // ----------------------------------------
    // registers
    // ----------------------------------------
    reg [7:0]  transport_sample_test_ctrl_reg;
    reg [7:0]  sync_ctrl_reg;
    reg [7:0]  interface_test_mode_ctrl_reg;
    reg [7:0]  link_layer_test_ctrl_reg;
    reg [15:0] user_pattern_word [0:3];
    reg [3:0]  mode_prev_reg;
    reg [30:0] lfsr_reg;
    reg [15:0] ramp_reg;
    reg [1:0]  user_idx_reg;
    reg        user_done_reg;
    reg        phase_reg;
    reg [7:0]  frame_cnt_reg;
    reg        sync_meta_reg;
    reg        sync_sync_reg;

    wire [3:0] mode   = interface_test_mode_ctrl_reg[3:0];
    wire [1:0] inj    = interface_test_mode_ctrl_reg[5:4];
    wire       tp_en  = transport_sample_test_ctrl_reg[`SLTP_TRANSPORT_EN_BIT];
    wire       fill_ready;
    wire       gen_valid = (mode == mode_prev_reg);  // no push in the restart cycle
    wire       frame_last;
    wire       step;
    wire [15:0] word_raw;
    reg  [15:0] word_sel;

    assign pat_inject_point = inj;
    // sample injection repeats each word over all samples of a frame
    assign frame_last = (inj != `SLTP_INJ_SAMPLE) ||
                        (frame_cnt_reg == NUM_CONV * SAMP_FRAME - 1);
    assign step = fill_ready && frame_last;

    // mask a 16-bit word to the width of the injection point
    function [15:0] fit_width;
        input [15:0] w;
        input [1:0]  ip;
        begin
            case (ip)
                `SLTP_INJ_PHY10: fit_width = {6'h00, w[9:0]};
                `SLTP_INJ_SCR8:  fit_width = {8'h00, w[7:0]};
                default:         fit_width = w;
            endcase
        end
    endfunction

    // user word taken from the top bits for the narrow injection points
    function [15:0] user_fit;
        input [15:0] w;
        input [1:0]  ip;
        begin
            case (ip)
                `SLTP_INJ_PHY10: user_fit = {6'h00, w[15:6]};
                `SLTP_INJ_SCR8:  user_fit = {9'h000, w[15:9]};
                default:         user_fit = w;
            endcase
        end
    endfunction

    // ----------------------------------------
    // register writes and soft reset
    // ----------------------------------------
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            transport_sample_test_ctrl_reg <= `SLTP_REG_RESET;
            sync_ctrl_reg                  <= `SLTP_REG_RESET;
            interface_test_mode_ctrl_reg   <= `SLTP_REG_RESET;
            link_layer_test_ctrl_reg       <= `SLTP_REG_RESET;
            soft_reset_pulse               <= 1'b0;
            user_pattern_word[0]           <= 16'h0000;
            user_pattern_word[1]           <= 16'h0000;
            user_pattern_word[2]           <= 16'h0000;
            user_pattern_word[3]           <= 16'h0000;
        end else begin
            soft_reset_pulse <= 1'b0;                                   // self clearing
            if (reg_wr && reg_addr == `SLTP_OFS_SOFT_RESET &&
                reg_wdata == `SLTP_SOFT_RESET_VAL) begin
                // soft reset returns all test controls to normal mode
                soft_reset_pulse               <= 1'b1;
                transport_sample_test_ctrl_reg <= `SLTP_REG_RESET;
                sync_ctrl_reg                  <= `SLTP_REG_RESET;
                interface_test_mode_ctrl_reg   <= `SLTP_REG_RESET;
                link_layer_test_ctrl_reg       <= `SLTP_REG_RESET;
            end else if (reg_wr) begin
                case (reg_addr)
                    `SLTP_OFS_TRANSPORT_TEST: transport_sample_test_ctrl_reg <= reg_wdata;
                    `SLTP_OFS_SYNC_CTRL:      sync_ctrl_reg                  <= reg_wdata;
                    // a zero mode write is ignored: only soft reset leaves test mode
                    `SLTP_OFS_IFACE_TEST:
                        if (reg_wdata[3:0] != `SLTP_MODE_OFF || mode == `SLTP_MODE_OFF)
                            interface_test_mode_ctrl_reg <= reg_wdata;
                    `SLTP_OFS_LINK_TEST:      link_layer_test_ctrl_reg <= reg_wdata;
                    default: begin
                        if (reg_addr >= `SLTP_OFS_USER_BASE &&
                            reg_addr <  `SLTP_OFS_USER_BASE + 12'd8) begin
                            // odd offset low byte, even offset high byte
                            if (reg_addr[0])
                                user_pattern_word[reg_addr[2:1]][7:0]  <= reg_wdata;
                            else
                                user_pattern_word[reg_addr[2:1] - 2'd1][15:8] <= reg_wdata;
                        end
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // register reads
    // ----------------------------------------
    always @(posedge clk_sys) begin
        if (!rst_n)
            reg_rdata <= 8'h00;
        else if (reg_rd) begin
            case (reg_addr)
                `SLTP_OFS_TRANSPORT_TEST: reg_rdata <= transport_sample_test_ctrl_reg;
                `SLTP_OFS_SYNC_CTRL:      reg_rdata <= sync_ctrl_reg;
                `SLTP_OFS_IFACE_TEST:     reg_rdata <= interface_test_mode_ctrl_reg;
                `SLTP_OFS_LINK_TEST:      reg_rdata <= {pat_active, 4'h0,
                                                        link_layer_test_ctrl_reg[2:0]};
                default:                  reg_rdata <= 8'h00;
            endcase
        end
    end

    // ----------------------------------------
    // sync request input synchroniser and masking
    // ----------------------------------------
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            sync_meta_reg <= 1'b1;
            sync_sync_reg <= 1'b1;
        end else begin
            sync_meta_reg <= link_sync_request_in_n;
            sync_sync_reg <= sync_meta_reg;
        end
    end
    // C0 in sync control forces the request inactive during link layer tests
    assign link_sync_req_n = (sync_ctrl_reg == `SLTP_SYNC_IGNORE_VAL) ? 1'b1
                                                                      : sync_sync_reg;

    // ----------------------------------------
    // status outputs
    // ----------------------------------------
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            pat_active    <= 1'b0;
            link_test_sel <= 3'b000;
        end else begin
            pat_active    <= (mode != `SLTP_MODE_OFF) || tp_en;
            link_test_sel <= link_layer_test_ctrl_reg[2:0];
        end
    end

    // ----------------------------------------
    // generator state: lfsr, ramp, user index, frame count
    // ----------------------------------------
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            mode_prev_reg <= `SLTP_MODE_OFF;
            lfsr_reg      <= 31'h0;
            ramp_reg      <= 16'h0000;
            user_idx_reg  <= 2'd0;
            user_done_reg <= 1'b0;
            phase_reg     <= 1'b0;
            frame_cnt_reg <= 8'h00;
        end else begin
            mode_prev_reg <= mode;
            if (mode != mode_prev_reg) begin
                // fresh start on any mode change so sequences begin at entry one
                case (mode)
                    `SLTP_MODE_PN31: lfsr_reg <= `SLTP_SEED_PN31;
                    `SLTP_MODE_PRBS_TWENTYTHREE_PATTERN: lfsr_reg <= {8'h00, `SLTP_SEED_PRBS_TWENTYTHREE_PATTERN};
                    `SLTP_MODE_PN15: lfsr_reg <= {16'h0000, `SLTP_SEED_PN15};
                    `SLTP_MODE_PN9:  lfsr_reg <= {22'h000000, `SLTP_SEED_PN9};
                    `SLTP_MODE_PN7:  lfsr_reg <= {24'h000000, `SLTP_SEED_PN7};
                    default:         lfsr_reg <= 31'h0;
                endcase
                ramp_reg      <= 16'h0000;
                user_idx_reg  <= 2'd0;
                user_done_reg <= 1'b0;
                phase_reg     <= 1'b0;
                frame_cnt_reg <= 8'h00;
            end else if (fill_ready) begin
                frame_cnt_reg <= frame_last ? 8'h00 : frame_cnt_reg + 8'h01;
                if (step) begin
                    phase_reg    <= ~phase_reg;
                    ramp_reg     <= ramp_reg + 16'h0001;
                    user_idx_reg <= user_idx_reg + 2'd1;
                    if (user_idx_reg == 2'd3)
                        user_done_reg <= 1'b1;
                    // fibonacci shift with the polynomial taps of each mode
                    case (mode)
                        `SLTP_MODE_PN31: lfsr_reg <= {lfsr_reg[29:0],
                                                      lfsr_reg[30] ^ lfsr_reg[27]};
                        `SLTP_MODE_PRBS_TWENTYTHREE_PATTERN: lfsr_reg <= {8'h00, lfsr_reg[21:0],
                                                      lfsr_reg[22] ^ lfsr_reg[17]};
                        `SLTP_MODE_PN15: lfsr_reg <= {16'h0000, lfsr_reg[13:0],
                                                      lfsr_reg[14] ^ lfsr_reg[13]};
                        `SLTP_MODE_PN9:  lfsr_reg <= {22'h000000, lfsr_reg[7:0],
                                                      lfsr_reg[8] ^ lfsr_reg[4]};
                        `SLTP_MODE_PN7:  lfsr_reg <= {24'h000000, lfsr_reg[5:0],
                                                      lfsr_reg[6] ^ lfsr_reg[5]};
                        default:         lfsr_reg <= lfsr_reg;
                    endcase
                end
            end
        end
    end

    // ----------------------------------------
    // word selection
    // ----------------------------------------
    always @* begin
        case (mode)
            `SLTP_MODE_CHECKER:
                word_sel = phase_reg ? `SLTP_CHECKER_B : `SLTP_CHECKER_A;
            `SLTP_MODE_TOGGLE:
                word_sel = phase_reg ? 16'hFFFF : 16'h0000;
            `SLTP_MODE_PN31,
            `SLTP_MODE_PRBS_TWENTYTHREE_PATTERN,
            `SLTP_MODE_PN15,
            `SLTP_MODE_PN9,
            `SLTP_MODE_PN7:
                word_sel = lfsr_reg[15:0];
            `SLTP_MODE_RAMP:
                word_sel = ramp_reg;
            `SLTP_MODE_USER_REPEAT:
                word_sel = user_fit(user_pattern_word[user_idx_reg], inj);
            `SLTP_MODE_USER_SINGLE:
                word_sel = user_done_reg ? 16'h0000
                         : user_fit(user_pattern_word[user_idx_reg], inj);
            default:
                word_sel = sample_in;
        endcase
    end
    // narrow injection points carry only the low bits of each step
    assign word_raw = fit_width(word_sel, inj);

    // ----------------------------------------
    // output buffer: a receiver stall holds the generator, no word lost
    // ----------------------------------------
    sltp_skid_buffer #(
        .WIDTH (16)
    ) u_buf (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .in_valid  (gen_valid),
        .in_ready  (fill_ready),
        .in_data   (word_raw),
        .out_valid (pat_valid),
        .out_ready (pat_ready),
        .out_data  (pat_data)
    );

endmodule // sltp_pattern_gen

//--- rtl/sltp_skid_buffer.v
// two-entry valid/ready buffer on the pattern data path
`timescale 1ns/1ps

module sltp_skid_buffer #(
    parameter WIDTH = 16
) (
    // clock and reset
    input  wire             clk_sys,
    input  wire             rst_n,
    // fill side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // drain side
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);

    reg [WIDTH-1:0] mem_reg [0:1];
    reg             wr_ptr_reg;
    reg             rd_ptr_reg;
    reg [1:0]       count_reg;

    wire push = in_valid && in_ready;
    wire pop  = out_valid && out_ready;

    assign in_ready  = (count_reg != 2'd2);   // honest full
    assign out_valid = (count_reg != 2'd0);   // honest empty
    assign out_data  = mem_reg[rd_ptr_reg];

    // ----------------------------------------
    // storage and pointers
    // ----------------------------------------
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg  <= 2'd0;
        end else begin
            if (push) begin
                mem_reg[wr_ptr_reg] <= in_data;
                wr_ptr_reg          <= ~wr_ptr_reg;
            end
            if (pop)
                rd_ptr_reg <= ~rd_ptr_reg;
            if (push && !pop)
                count_reg <= count_reg + 2'd1;
            else if (pop && !push)
                count_reg <= count_reg - 2'd1;
        end
    end

endmodule // sltp_skid_buffer
